/* design/sgc_blink.sv */
// Blink generator: two blink phases with selectable rates and burst toggle
`timescale 1ns/1ps
module sgc_blink #(
	parameter int HALF_CYC = sgc_pkg::BLINK_HALF_CYC
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Rate selects and control
	input  wire logic [1:0] blink_rate_zero,
	input  wire logic [1:0] blink_rate_one,
	input  wire logic       hold,
	input  wire logic       burst_done,
	// Blink phases
	output logic            blink0,
	output logic            blink1
);
	import sgc_pkg::*;

	sgc_bl_s st_r;
	sgc_bl_s st_nxt;

	// Prescaler steps each half period of the fastest rate; div bits halve it
	always_comb begin
		st_nxt = st_r;
		if (hold) begin
			st_nxt = '0;
		end else begin
			if (st_r.pre >= 23'(HALF_CYC - 1)) begin
				st_nxt.pre = 23'h000000;
				st_nxt.div = st_r.div + 4'h1;
			end else begin
				st_nxt.pre = st_r.pre + 23'h000001;
			end
			if (burst_done) begin
				st_nxt.tog = !st_r.tog;
			end
			st_nxt.b0 = st_nxt.div[blink_rate_zero];
			// rate one, code three toggles per burst
			st_nxt.b1 = (blink_rate_one == BM_TOGGLE) ? st_nxt.tog : st_nxt.div[blink_rate_one];
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign blink0 = st_r.b0;
	assign blink1 = st_r.b1;

	a_blink_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		hold |=> (!blink0 && !blink1)) else $error("blink not held in reset");
endmodule

/* design/sgc_ctrl.sv */
// Serial gpio controller: APB registers, burst engine, shift chain, input capture
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module sgc_ctrl #(
	parameter int BLINK_HALF = sgc_pkg::BLINK_HALF_CYC,
	parameter int GAP_STEP   = sgc_pkg::GAP_STEP_CYC
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// APB slave
	input  wire sgc_pkg::sgc_apb_req_s apb_req,
	output sgc_pkg::sgc_apb_rsp_s     apb_rsp,
	// Port link activity, same clock
	input  wire logic [31:0]          link_act,
	// Serial chain
	input  wire logic                 sdin,
	output sgc_pkg::sgc_link_s        link,
	// Loss of signal per port
	output logic [31:0]               los
);
	import sgc_pkg::*;

	sgc_st_s     st;
	sgc_st_s     n;
	logic [31:0] rd_val;
	logic        hit;
	logic [7:0]  poff;
	logic [4:0]  pidx;
	logic [1:0]  ri;
	logic        acc;
	logic        wr;
	logic [1:0]  w;
	logic        run;
	logic        last;
	logic        adv;
	logic        bitv;
	logic        cond;
	logic        ien;
	logic [2:0]  sel;
	logic [6:0]  nxt_pos;
	logic [11:0] div_end;
	logic [23:0] gap_cyc;
	logic        blink0;
	logic        blink1;

	// Walk helpers: ascending is port 0 bit 0 upward
	function automatic logic [6:0] walk_start(input logic asc, input logic [1:0] wd);
		logic [6:0] r;
		r = asc ? 7'h00 : {5'(NP - 1), wd};
		return r;
	endfunction

	function automatic logic [6:0] walk_step(input logic [4:0] p, input logic [1:0] b,
		input logic asc, input logic [1:0] wd);
		logic [6:0] r;
		if (asc) begin
			r = (b < wd) ? {p, b + 2'h1} : {p + 5'h01, 2'h0};
		end else begin
			r = (b != 2'h0) ? {p, b - 2'h1} : {p - 5'h01, wd};
		end
		return r;
	endfunction

	// Width may shrink mid-burst, so the ascending end tests b >= wd
	function automatic logic walk_last(input logic [4:0] p, input logic [1:0] b,
		input logic asc, input logic [1:0] wd);
		logic r;
		r = asc ? (p == 5'(NP - 1) && b >= wd) : (p == 5'h00 && b == 2'h0);
		return r;
	endfunction

	function automatic logic src_bit(input logic [2:0] s, input logic b0, input logic b1,
		input logic act);
		logic r;
		case (s)
			SRC_LOW:   r = 1'b0;
			SRC_HIGH:  r = 1'b1;
			SRC_BL0:   r = b0;
			SRC_BL1:   r = b1;
			SRC_ACT0:  r = act & b0;
			SRC_ACT1:  r = act & b1;
			SRC_IACT0: r = !(act & b0);
			default:   r = 1'b0;
		endcase
		return r;
	endfunction

	// Blink phases; burst end advances the burst toggle
	sgc_blink #(
		.HALF_CYC(BLINK_HALF)
	) u_blink (
		.core_clk       (core_clk),
		.rst_n          (rst_n),
		.blink_rate_zero(st.cfg[B_BM0 +: 2]),
		.blink_rate_one (st.cfg[B_BM1 +: 2]),
		.hold           (st.cfg[B_BRST]),
		.burst_done     (st.done),
		.blink0         (blink0),
		.blink1         (blink1)
	);

	// Gap length is (field + 1) steps
	assign gap_cyc = 24'((int'(st.cfg[B_GAP +: 5]) + 1) * GAP_STEP - 1);

	// Address decode and read mux
	always_comb begin
		poff   = apb_req.paddr - A_PCFG;
		pidx   = poff[6:2];
		ri     = apb_req.paddr[3:2];
		rd_val = WORD_RST;
		hit    = (apb_req.paddr[1:0] == 2'b00);
		if (apb_req.paddr < A_POL) begin
			// disabled port bits returned as last captured
			rd_val = st.in_data[ri];
		end else if (apb_req.paddr < A_PIE) begin
			rd_val = st.pol[ri];
		end else if (apb_req.paddr == A_PIE) begin
			rd_val = st.port_irq;
		end else if (apb_req.paddr < A_PEN) begin
			rd_val = {20'h00000, st.port_cfg[pidx]};
		end else if (apb_req.paddr == A_PEN) begin
			rd_val = st.port_en;
		end else if (apb_req.paddr == A_CFG) begin
			rd_val = {10'h000, st.cfg};
		end else if (apb_req.paddr == A_CLK) begin
			rd_val = {20'h00000, st.clk_div};
		end else if (apb_req.paddr >= A_INT && apb_req.paddr < A_END) begin
			rd_val = st.irq[ri] & st.port_en & st.port_irq & {32{st.cfg[B_BIE + int'(ri)]}};
		end else begin
			hit = 1'b0;
		end
	end

	// Next state of the whole controller
	always_comb begin
		n       = st;
		w       = st.cfg[B_PW +: 2];
		// divider below two stops the chain
		run     = st.clk_div >= 12'(DIV_MIN);
		div_end = st.clk_div - 12'h001;
		last    = walk_last(st.port, st.bit_i, st.dir, w);
		nxt_pos = walk_step(st.port, st.bit_i, st.dir, w);
		// three select bits per output bit
		sel     = st.port_cfg[st.port][3 * st.bit_i +: 3];
		bitv    = src_bit(sel, blink0, blink1, link_act[st.port]);
		// polarity zero flags a high value
		cond    = st.rx[0] ^ st.pol[st.bit_i][st.port];
		ien     = st.port_irq[st.port] & st.cfg[B_BIE + int'(st.bit_i)];
		adv     = 1'b0;
		n.done  = 1'b0;
		n.rsp.pready = 1'b0;
		// Serial input synchroniser
		n.sin_meta = sdin;
		n.sin_sync = st.sin_meta;

		// APB: answer one cycle into the access phase, write on the pready edge
		acc = apb_req.psel & apb_req.penable;
		wr  = acc & st.rsp.pready & apb_req.pwrite & hit;
		if (acc && !st.rsp.pready) begin
			n.rsp.pready  = 1'b1;
			n.rsp.prdata  = rd_val;
			n.rsp.pslverr = !hit;
		end
		if (wr) begin
			if (apb_req.paddr >= A_POL && apb_req.paddr < A_PIE) begin
				n.pol[ri] = apb_req.pwdata;
			end else if (apb_req.paddr == A_PIE) begin
				n.port_irq = apb_req.pwdata;
			end else if (apb_req.paddr >= A_PCFG && apb_req.paddr < A_PEN) begin
				n.port_cfg[pidx] = apb_req.pwdata[11:0];
			end else if (apb_req.paddr == A_PEN) begin
				n.port_en = apb_req.pwdata;
			end else if (apb_req.paddr == A_CFG) begin
				n.cfg = apb_req.pwdata[CW-1:0];
			end else if (apb_req.paddr == A_CLK) begin
				n.clk_div = apb_req.pwdata[11:0];
			end else if (apb_req.paddr >= A_INT) begin
				// Write one to clear; a set below in the same cycle wins
				n.irq[ri] = st.irq[ri] & ~apb_req.pwdata;
			end
		end

		// Burst engine
		case (st.state)
			ST_IDLE: begin
				// either start bit launches a burst
				if (run && (st.cfg[B_SS] || st.cfg[B_AR])) begin
					n.state  = ST_LOAD;
					n.divcnt = 12'h000;
				end
			end
			ST_LOAD: begin
				if (run) begin
					if (st.divcnt >= div_end) begin
						n.divcnt = 12'h000;
						n.state  = ST_SHIFT;
						n.dir = st.cfg[B_ROUT];
						{n.port, n.bit_i} = walk_start(st.cfg[B_ROUT], w);
					end else begin
						n.divcnt = st.divcnt + 12'h001;
					end
				end
			end
			ST_SHIFT: begin
				// disabled ports take no slot on the wire
				if (!st.port_en[st.port]) begin
					adv = 1'b1;
				end else if (run) begin
					n.link.sclk = st.divcnt > {1'b0, div_end[11:1]};
					if (st.divcnt == 12'h000) begin
						n.link.sdout = bitv;
					end
					if (st.divcnt >= div_end) begin
						n.rx     = {st.rx[NP*NB-2:0], st.sin_sync};
						n.divcnt = 12'h000;
						adv      = 1'b1;
					end else begin
						n.divcnt = st.divcnt + 12'h001;
					end
				end
				if (adv) begin
					{n.port, n.bit_i} = nxt_pos;
					if (last) begin
						// unload walks opposite to the received order
						n.state = ST_DIST;
						n.dir   = st.cfg[B_RIN];
						{n.port, n.bit_i} = walk_start(st.cfg[B_RIN], w);
					end
				end
			end
			ST_DIST: begin
				if (st.port_en[st.port]) begin
					// port M bit N lands in word N bit M
					n.rx = st.rx >> 1;
					n.in_data[st.bit_i][st.port] = st.rx[0];
					if (cond && ien) begin
						n.irq[st.bit_i][st.port] = 1'b1;
					end
				end
				{n.port, n.bit_i} = nxt_pos;
				if (last) begin
					n.done = 1'b1;
					// single shot clears when its burst ends
					n.cfg[B_SS] = 1'b0;
					n.divcnt    = 12'h000;
					if (st.cfg[B_AR]) begin
						n.state  = st.cfg[B_GDIS] ? ST_LOAD : ST_GAP;
						n.gapcnt = gap_cyc;
					end else begin
						n.state = ST_IDLE;
					end
				end
			end
			ST_GAP: begin
				// idle gap, then repeat while enabled
				if (st.gapcnt == 24'h000000) begin
					n.state = (run && (st.cfg[B_AR] || st.cfg[B_SS])) ? ST_LOAD : ST_IDLE;
				end else begin
					n.gapcnt = st.gapcnt - 24'h000001;
				end
			end
			default: begin
				n.state = ST_IDLE;
			end
		endcase

		// Clock rests low outside the shift phase
		if (n.state != ST_SHIFT) begin
			n.link.sclk = 1'b0;
		end
		// load strobe level follows polarity bit
		n.link.load = !((n.state == ST_LOAD) ^ st.cfg[B_LDP]);
		// loss output carries raw bit 0, polarity not applied
		n.los = n.in_data[0];
	end

	// State register; load strobe idles high for the reset polarity
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st           <= '0;
			st.link.load <= 1'b1;
		end else begin
			st <= n;
		end
	end

	assign apb_rsp = st.rsp;
	assign link    = st.link;
	assign los     = st.los;

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_finish;
		st.state == ST_DIST && last;
	endsequence

	sequence s_to_gap;
		s_finish ##0 (st.cfg[B_AR] && !st.cfg[B_GDIS]);
	endsequence

	a_apb_pulse: assert property (
		st.rsp.pready |=> !st.rsp.pready) else $error("pready held past one cycle");

	a_load_level: assert property (
		(st.state == ST_LOAD && $stable(st.cfg[B_LDP])) |-> (link.load == st.cfg[B_LDP]))
		else $error("load strobe not at active level");

	a_idle_load: assert property (
		(st.state == ST_IDLE && $stable(st.cfg[B_LDP])) |-> (link.load != st.cfg[B_LDP]))
		else $error("load strobe active while idle");

	a_gap_skip: assert property (
		s_finish ##0 (st.cfg[B_AR] && st.cfg[B_GDIS]) |=> st.state == ST_LOAD)
		else $error("gap not skipped");

	a_gap_length: assert property (
		s_to_gap |=> (st.state == ST_GAP && st.gapcnt == $past(gap_cyc)))
		else $error("gap length wrong");

	a_single_done: assert property (
		s_finish ##0 !st.cfg[B_AR] |=> (st.state == ST_IDLE && !st.cfg[B_SS]))
		else $error("single shot did not end");

	a_div_stall: assert property (
		(st.state == ST_SHIFT && st.clk_div < 12'(DIV_MIN) && st.port_en[st.port])
		|=> ($stable(st.port) && $stable(st.bit_i))) else $error("shift ran without clock");

	a_in_store: assert property (
		(st.state == ST_DIST && st.port_en[st.port])
		|=> st.in_data[$past(st.bit_i)][$past(st.port)] == $past(st.rx[0]))
		else $error("input bit stored at wrong place");

	a_irq_cause: assert property (
		$rose(st.irq[0][0]) |-> $past(st.port_en[0] && st.port_irq[0] && st.cfg[B_BIE]))
		else $error("interrupt set while disabled");

	a_irq_sticky: assert property (
		(st.irq[0][0] && !wr) |=> st.irq[0][0]) else $error("sticky bit lost");
endmodule

/* design/sgc_pkg.sv */
// Package: constants, carrier types and state records of the serial gpio controller
package sgc_pkg;
	// Chain geometry
	localparam int NP = 32;
	localparam int NB = 4;
	localparam int CW = 22;

	// Register byte offsets
	localparam logic [7:0] A_IN     = 8'h00;
	localparam logic [7:0] A_POL    = 8'h10;
	localparam logic [7:0] A_PIE    = 8'h20;
	localparam logic [7:0] A_PCFG   = 8'h24;
	localparam logic [7:0] A_PEN    = 8'ha4;
	localparam logic [7:0] A_CFG    = 8'ha8;
	localparam logic [7:0] A_CLK    = 8'hac;
	localparam logic [7:0] A_INT    = 8'hb0;
	localparam logic [7:0] A_END    = 8'hc0;

	// Chain configuration field positions
	localparam int B_BM1  = 20;
	localparam int B_BM0  = 18;
	localparam int B_BRST = 17;
	localparam int B_BIE  = 13;
	localparam int B_GDIS = 12;
	localparam int B_GAP  = 7;
	localparam int B_SS   = 6;
	localparam int B_AR   = 5;
	localparam int B_LDP  = 4;
	localparam int B_PW   = 2;
	localparam int B_ROUT = 1;
	localparam int B_RIN  = 0;

	// Reset values
	localparam logic [CW-1:0] CFG_RST  = 22'h000000;
	localparam logic [11:0]   CLK_RST  = 12'h000;
	localparam logic [31:0]   WORD_RST = 32'h00000000;

	// Output source selector codes and the blink toggle rate code
	localparam logic [2:0] SRC_LOW   = 3'h0;
	localparam logic [2:0] SRC_HIGH  = 3'h1;
	localparam logic [2:0] SRC_BL0   = 3'h2;
	localparam logic [2:0] SRC_BL1   = 3'h3;
	localparam logic [2:0] SRC_ACT0  = 3'h4;
	localparam logic [2:0] SRC_ACT1  = 3'h5;
	localparam logic [2:0] SRC_IACT0 = 3'h6;
	localparam logic [1:0] BM_TOGGLE = 2'h3;

	// Timing
	localparam int CLK_NS         = 8;
	localparam int BLINK_HALF_NS  = 25000000;
	localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_NS;
	localparam int GAP_STEP_NS    = 1050000;
	localparam int GAP_STEP_CYC   = GAP_STEP_NS / CLK_NS;
	localparam int DIV_MIN        = 2;

	// Bus and link carriers
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} sgc_apb_req_s;
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} sgc_apb_rsp_s;
	typedef struct packed {
		logic sclk;
		logic sdout;
		logic load;
	} sgc_link_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LOAD  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_DIST  = 3'b011,
		ST_GAP   = 3'b100
	} sgc_state_e;

	// Controller state
	typedef struct packed {
		sgc_state_e              state;
		logic [NB-1:0][31:0]     in_data;
		logic [NB-1:0][31:0]     pol;
		logic [NB-1:0][31:0]     irq;
		logic [31:0]             port_irq;
		logic [31:0]             port_en;
		logic [NP-1:0][11:0]     port_cfg;
		logic [CW-1:0]           cfg;
		logic [11:0]             clk_div;
		logic [11:0]             divcnt;
		logic [4:0]              port;
		logic [1:0]              bit_i;
		logic                    dir;
		logic [23:0]             gapcnt;
		logic [NP*NB-1:0]        rx;
		logic                    sin_meta;
		logic                    sin_sync;
		logic                    done;
		logic [NP-1:0]           los;
		sgc_link_s               link;
		sgc_apb_rsp_s            rsp;
	} sgc_st_s;

	// Blink generator state
	typedef struct packed {
		logic [22:0] pre;
		logic [3:0]  div;
		logic        tog;
		logic        b0;
		logic        b1;
	} sgc_bl_s;
endpackage

/* testbench/serial_gpio_controller_tb_top.sv */
// Self-checking testbench for the serial gpio controller
`timescale 1ns/1ps
module serial_gpio_controller_tb_top;
	import sgc_pkg::*;
	logic         core_clk;
	logic         rst_n;
	sgc_apb_req_s apb_req;
	sgc_apb_rsp_s apb_rsp;
	logic [31:0]  link_act;
	logic [31:0]  los;
	logic         sdin;
	sgc_link_s    link;
	logic [127:0] pattern;
	logic [127:0] got;
	logic         ldp;
	logic [31:0]  rd;
	logic         err;
	int           mismatches = 0;
	int           checks_done = 0;

	// Short blink and gap counts keep the run brief
	sgc_ctrl #(.BLINK_HALF(8), .GAP_STEP(16)) DUT (
		.core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.link_act(link_act), .sdin(sdin), .link(link), .los(los));
	sgc_chain_model chain (
		.sclk(link.sclk), .sdout(link.sdout), .load(link.load), .load_lvl(ldp),
		.pattern(pattern), .sdin(sdin), .got(got));

	// Clock at 125 MHz
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 50);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		if (n >= 50) chk("pready", 32'h0, 32'h1);
		apb_req <= '0;
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask

	// Starts one burst and polls until the single shot bit drops
	task automatic burst(input logic [31:0] cfg);
		apb(1'b1, A_CFG, cfg | (32'h1 << B_SS));
		rd = '1;
		for (int i = 0; i < 200 && rd[B_SS] !== 1'b0; i++) apb(1'b0, A_CFG, 32'h0);
		chk("single shot clear", rd, cfg);
	endtask

	task automatic t_reset;
		logic [7:0] al [7];
		al = '{A_IN, A_POL, A_PIE, A_PEN, A_CFG, A_CLK, A_INT};
		foreach (al[i]) rchk("reset value", al[i], WORD_RST);
		apb(1'b0, A_END, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		apb(1'b1, A_IN, 32'hffffffff);
		rchk("input read only", A_IN, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_rw;
		apb(1'b1, A_POL + 8'h4, 32'h5a5a0f0f);
		rchk("polarity word", A_POL + 8'h4, 32'h5a5a0f0f);
		apb(1'b1, A_PIE, 32'h80000001);
		rchk("port irq enable", A_PIE, 32'h80000001);
		apb(1'b1, A_PCFG + 8'h14, 32'h00000abc);
		rchk("source field", A_PCFG + 8'h14, 32'h00000abc);
		apb(1'b1, A_PEN, 32'hc0000003);
		rchk("port enable", A_PEN, 32'hc0000003);
		apb(1'b1, A_POL + 8'h4, 32'h0);
		$display("test rw done");
	endtask

	// Ports 0 and 1, two gpios each, default orders, active low strobe
	task automatic t_default;
		pattern = 128'h9;
		apb(1'b1, A_PEN, 32'h3);
		apb(1'b1, A_PCFG, {20'h0, 3'h0, 3'h0, SRC_HIGH, SRC_HIGH});
		apb(1'b1, A_PCFG + 8'h4, 32'h0);
		apb(1'b1, A_PIE, 32'h3);
		apb(1'b1, A_CLK, 32'h8);
		burst((32'h3 << B_BIE) | (32'h1 << B_PW));
		chk("output order", {28'h0, got[3:0]}, 32'h3);
		rchk("input word0", A_IN, 32'h1);
		rchk("input word1", A_IN + 8'h4, 32'h2);
		rchk("irq word0", A_INT, 32'h1);
		rchk("irq word1", A_INT + 8'h4, 32'h2);
		chk("loss output", {30'h0, los[1:0]}, 32'h1);
		chk("load idle", {31'h0, link.load}, 32'h1);
		apb(1'b1, A_INT, 32'h1);
		rchk("irq cleared", A_INT, 32'h0);
		$display("test default order done");
	endtask

	// Reversed orders, active high strobe, low polarity, bit one masked
	task automatic t_reverse;
		pattern = 128'h3;
		ldp = 1'b1;
		apb(1'b1, A_POL, 32'h3);
		apb(1'b1, A_PIE, 32'h1);
		burst((32'h1 << B_BIE) | (32'h1 << B_PW) | 32'h13);
		chk("reversed output", {28'h0, got[3:0]}, 32'hc);
		rchk("rev input word0", A_IN, 32'h2);
		rchk("rev input word1", A_IN + 8'h4, 32'h2);
		rchk("low polarity irq", A_INT, 32'h1);
		rchk("bit index masked", A_INT + 8'h4, 32'h0);
		chk("loss raw", {30'h0, los[1:0]}, 32'h2);
		chk("load idle high pol", {31'h0, link.load}, 32'h0);
		$display("test reverse done");
	endtask

	// Auto repeat with and without the gap; bursts counted by load strobe rises
	task automatic t_repeat;
		int   nb [3];
		logic prev;
		for (int g = 0; g < 2; g++) begin
			apb(1'b1, A_CFG, (32'h1 << B_AR) | (32'h1 << B_LDP) | (32'h1 << B_PW)
				| (32'(g) << B_GDIS) | (32'h5 << B_GAP));
			nb[g] = 0;
			prev = 1'b0;
			repeat (1000) begin
				@(posedge core_clk);
				if (link.load && !prev) nb[g]++;
				prev = link.load;
			end
			apb(1'b1, A_CFG, 32'h1 << B_LDP);
			repeat (300) @(posedge core_clk);
		end
		nb[2] = 0;
		prev = link.load;
		repeat (300) begin
			@(posedge core_clk);
			if (link.load && !prev) nb[2]++;
			prev = link.load;
		end
		chk("gapped repeats", {31'h0, nb[0] >= 2}, 32'h1);
		chk("gap removed", {31'h0, nb[1] > nb[0]}, 32'h1);
		chk("repeat stopped", 32'(nb[2]), 32'h0);
		$display("test repeat done");
	endtask

	// A zero divider blocks the start of a burst
	task automatic t_nodiv;
		apb(1'b1, A_CLK, 32'h0);
		apb(1'b1, A_CFG, 32'h1 << B_SS);
		repeat (60) @(posedge core_clk);
		chk("no shift clock", {31'h0, link.sclk}, 32'h0);
		rchk("shot pending", A_CFG, 32'h1 << B_SS);
		$display("test divider off done");
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial begin
		#(8 * 60000);
		mismatches++;
		summarize();
	end

	// Main sequence
	initial begin
		apb_req = '0;
		link_act = '0;
		pattern = '0;
		ldp = 1'b0;
		rst_n = 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_rw();
		t_default();
		t_reverse();
		t_repeat();
		t_nodiv();
		summarize();
	end
endmodule

/* testbench/sgc_chain_model.sv */
// Behavioural shift register chain that sits on the far end of the serial link
`timescale 1ns/1ps
module sgc_chain_model (
	// Link from the controller
	input  wire logic         sclk,
	input  wire logic         sdout,
	input  wire logic         load,
	input  wire logic         load_lvl,
	// Parallel inputs and captured outputs
	input  wire logic [127:0] pattern,
	output logic              sdin,
	output logic [127:0]      got
);
	logic [127:0] in_sr = '0;
	wire          ld_act = (load === load_lvl);
	initial got = '0;
	// Output bits shift in on the rising shift clock, the first sent ends highest
	always @(posedge sclk) begin
		got <= {got[126:0], sdout};
	end
	// Inputs advance on the falling clock so each bit stands a whole slot
	always @(negedge sclk or posedge ld_act) begin
		if (ld_act) begin
			in_sr <= pattern;
		end else begin
			in_sr <= in_sr >> 1;
		end
	end
	assign sdin = in_sr[0];
endmodule
